// *** dv/sadc_host.sv ***
// Host serial master model for the converter link.
`timescale 1ns/10ps
`default_nettype none
module sadc_host (
  output logic     sclk_o,
  output logic     cs_n_o,
  output logic     din_o,
  input wire logic dout_i,
  input wire logic busy_i
);
  initial begin
    sclk_o = 1'h0;
    cs_n_o = 1'h1;
    din_o  = 1'h0;
  end
  // Data changes right after the falling edge, so it holds across the rising one.
  task automatic xfer(input logic [63:0] tx, input int n, input real hp, output logic [63:0] rx,
                      output logic [63:0] rb);
    rx = '0;
    rb = '0;
    cs_n_o = 1'h0;
    #(2 * hp);
    for (int k = 1; k <= n; k++) begin
      din_o = tx[k];
      #(hp);
      sclk_o = 1'h1;
      rx[k] = dout_i;
      rb[k] = busy_i;
      #(hp);
      sclk_o = 1'h0;
    end
    #(hp);
    cs_n_o = 1'h1;
    din_o = ~din_o;
  endtask
endmodule
`default_nettype wire

// *** dv/sadc_sva.sv ***
// Port checker for the serial converter interface.
`timescale 1ns/10ps
`default_nettype none
module sadc_chk (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       serial_clock_in_i,
  input wire logic       chip_select_n_i,
  input wire logic       power_off_input_low_n_i,
  input wire logic       serial_data_oe_o,
  input wire logic       busy_o,
  input wire logic       busy_oe_o,
  input wire logic       conv_start_o,
  input wire logic [1:0] power_select_bits_o,
  input wire logic       power_down_o
);
  property p_oe_off;
    @(posedge clk_i) disable iff (!rst_n_i) chip_select_n_i |-> !serial_data_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("data enable while deselected");
  property p_busy_off;
    @(posedge clk_i) disable iff (!rst_n_i) chip_select_n_i |-> !busy_oe_o;
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("busy enable while deselected");
  property p_busy_one;
    @(negedge serial_clock_in_i) disable iff (!rst_n_i || chip_select_n_i) $rose(busy_o) |=> !busy_o;
  endproperty
  a_busy_one: assert property (p_busy_one) else $error("busy longer than one cycle");
  property p_busy_drv;
    @(negedge serial_clock_in_i) disable iff (!rst_n_i || chip_select_n_i) busy_o |-> busy_oe_o;
  endproperty
  a_busy_drv: assert property (p_busy_drv) else $error("busy high but not driven");
  property p_busy_start;
    @(posedge clk_i) disable iff (!rst_n_i) $rose(busy_o) |-> ##[0:4] conv_start_o;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("no start after busy");
  property p_start_gap;
    @(posedge clk_i) disable iff (!rst_n_i) conv_start_o |=> !conv_start_o [*8];
  endproperty
  a_start_gap: assert property (p_start_gap) else $error("start pulse repeated");
  property p_power_off_input_low;
    @(posedge clk_i) disable iff (!rst_n_i) !power_off_input_low_n_i [*4] |-> power_down_o;
  endproperty
  a_power_off_input_low: assert property (p_power_off_input_low) else $error("shutdown not honoured");
  property p_wake;
    @(posedge clk_i) disable iff (!rst_n_i) power_off_input_low_n_i [*4] ##0 conv_start_o |=> !power_down_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake at start");
  property p_full;
    @(posedge clk_i) disable iff (!rst_n_i)
      power_off_input_low_n_i [*4] ##0 (power_select_bits_o != 2'h0) |=> !power_down_o;
  endproperty
  a_full: assert property (p_full) else $error("powered down in full power");
endmodule
`default_nettype wire

// *** dv/sadc_top_tb_top.sv ***
// Self-checking bench of the serial converter interface.
`timescale 1ns/10ps
`default_nettype none
module sadc_top_tb_top;
  import sadc_pkg::*;
  logic        clk_i, rst_n_i, resolution_enable_i, power_off_input_low_n_i, sample_valid_i, sample_ready_o;
  logic        serial_clock_in_i, chip_select_n_i, serial_data_i, serial_data_o, serial_data_oe_o;
  logic        busy_o, busy_oe_o, conv_start_o, input_type_select_o, conv_short_o, power_down_o;
  logic [2:0]  channel_select_bits_o;
  logic [1:0]  power_select_bits_o, pd;
  logic [31:0] rs;
  sadc_word_t  sample_data_i;
  sadc_word_t  sq[$];
  int          err_total, cmp_count, n_start, n_exp, cyc;
  wire logic   dout_w = serial_data_oe_o ? serial_data_o : 1'hz;
  wire logic   busy_w = busy_oe_o ? busy_o : 1'hz;
  sadc_top i_sadc_top (
    .clk_i, .rst_n_i, .serial_clock_in_i, .chip_select_n_i, .serial_data_i, .resolution_enable_i,
    .power_off_input_low_n_i, .serial_data_o, .serial_data_oe_o, .busy_o, .busy_oe_o, .sample_data_i,
    .sample_valid_i, .sample_ready_o, .conv_start_o, .channel_select_bits_o, .input_type_select_o,
    .conv_short_o, .power_select_bits_o, .power_down_o
  );
  sadc_host i_sadc_host (.sclk_o(serial_clock_in_i), .cs_n_o(chip_select_n_i), .din_o(serial_data_i),
                         .dout_i(dout_w), .busy_i(busy_w));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic fill(input int n);
    for (int t = 0; t < n; t++) begin
      sample_valid_i <= 1'h1;
      sample_data_i <= sadc_word_t'(rnd());
      @(posedge clk_i);
      if (sample_ready_o === 1'h1) sq.push_back(sample_data_i);
    end
    sample_valid_i <= 1'h0;
  endtask
  // Rise 1 sees floating pins, so rises 0 and 1 are masked out.
  task automatic frame(input int nc, input logic md, input logic re, input real hp, input int cut);
    logic [63:0] tx, ed, eb, rx, rb, m;
    logic [31:0] r;
    logic [7:0]  c, st, gv;
    sadc_word_t  s;
    int          p, w, g, n;
    logic        sh;
    resolution_enable_i <= re;
    sh = md & re;
    w = sh ? 8 : 12;
    g = sh ? 10 : 14;
    tx = '0;
    ed = '0;
    eb = '0;
    p = 3;
    for (int k = 0; k < nc; k++) begin
      r = rnd();
      c = {1'h1, r[2:0], md, r[3], pd};
      for (int j = 0; j < 8; j++) tx[p+j] = c[7-j];
      for (int j = 8; j < g; j++) tx[p+j] = 1'h1;
      s = (sq.size() > 0) ? sq.pop_front() : '0;
      eb[p+8] = 1'h1;
      for (int j = 0; j < w; j++) ed[p+9+j] = s[11-j];
      n_exp++;
      p = p + g;
    end
    n = (cut > 0) ? cut : p - g + 9 + w;
    m = ((64'h1 << (n + 1)) - 64'h1) & ~64'h3;
    i_sadc_host.xfer(tx, n, hp, rx, rb);
    repeat (30) @(posedge clk_i);
    st = {c[6:4], c[2], sh, pd, pd == 2'h0 && cut == 0};
    gv = {channel_select_bits_o, input_type_select_o, conv_short_o, power_select_bits_o, power_down_o};
    chk("dout", ed & m, rx & m);
    chk("busy", eb & m, rb & m);
    chk("enables", 64'h0, 64'({serial_data_oe_o, busy_oe_o}));
    chk("status", 64'(st), 64'(gv));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (conv_start_o === 1'h1) n_start++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    rs = 32'h15170;
    err_total = 0;
    cmp_count = 0;
    n_start = 0;
    n_exp = 0;
    cyc = 0;
    pd = 2'h3;
    rst_n_i = 1'h0;
    resolution_enable_i = 1'h1;
    power_off_input_low_n_i = 1'h1;
    sample_valid_i = 1'h0;
    sample_data_i = '0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    chk("reset", 64'he, 64'({sample_ready_o, power_select_bits_o, power_down_o}));
    fill(4);
    frame(1, 1'h0, 1'h1, 6.0, 0);
    frame(3, 1'h0, 1'h1, 6.0, 0);
    fill(6);
    frame(5, 1'h1, 1'h1, 4.1, 0);
    frame(2, 1'h1, 1'h0, 6.0, 0);
    $display("test link done");
    pd = 2'h0;
    frame(2, 1'h0, 1'h1, 6.0, 0);
    frame(1, 1'h0, 1'h1, 6.0, 0);
    pd = 2'h3;
    frame(1, 1'h0, 1'h1, 6.0, 14);
    power_off_input_low_n_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    chk("shutdown", 64'h1, 64'(power_down_o));
    power_off_input_low_n_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    chk("wake", 64'h0, 64'(power_down_o));
    $display("test power done");
    fill(64);
    chk("full", 64'h0, 64'(sample_ready_o));
    while (sq.size() > 0) frame(5, 1'h1, 1'h1, 6.0, 0);
    frame(1, 1'h0, 1'h1, 6.0, 0);
    chk("ready", 64'h1, 64'(sample_ready_o));
    chk("starts", 64'(n_exp), 64'(n_start));
    $display("test buffer done");
    complete_run();
  end
endmodule
bind sadc_top sadc_chk i_sadc_chk (.clk_i, .rst_n_i, .serial_clock_in_i, .chip_select_n_i, .power_off_input_low_n_i,
  .serial_data_oe_o, .busy_o, .busy_oe_o, .conv_start_o, .power_select_bits_o, .power_down_o);
`default_nettype wire

// *** hdl/sadc_defs.svh ***
// Shared constants of the serial converter interface.
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

`define SADC_WORD_W        12
`define SADC_CNT_W         4
`define SADC_FIFO_DEPTH    32
`define SADC_RES_FULL      4'hc
`define SADC_RES_SHORT     4'h8
`define SADC_HOLDOFF_FULL  4'h6
`define SADC_HOLDOFF_SHORT 4'h2
`define SADC_CTRL_LAST     4'h6
`define SADC_CTRL_W        7
`define SADC_CH_HI         6
`define SADC_CH_LO         4
`define SADC_MODE_BIT      3
`define SADC_TYPE_BIT      2
`define SADC_PD_HI         1
`define SADC_PD_LO         0
`define SADC_PD_AUTO       2'h0
`define SADC_PD_FULL       2'h3

`endif

// *** hdl/sadc_fifo.sv ***
// Sample FIFO with registered read data and registered full indication.
`timescale 1ns/10ps
`default_nettype none
`include "sadc_defs.svh"

module sadc_fifo #(
  parameter int WIDTH = `SADC_WORD_W,
  parameter int DEPTH = `SADC_FIFO_DEPTH
) (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  sadc_stream_if.snk  wr_if,
  sadc_stream_if.src  rd_if
);
  import sadc_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             in_ready_r;
  logic             out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  logic             push;
  logic             pop;

  assign push          = wr_if.valid & in_ready_r;
  assign pop           = (count_r != '0) & (~out_valid_r | rd_if.ready);
  assign count_nxt     = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign wr_if.ready   = in_ready_r;
  assign rd_if.valid   = out_valid_r;
  assign rd_if.data    = out_data_r;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= wr_if.data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      in_ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r    <= count_nxt;
      in_ready_r <= (count_nxt != FULL_CNT);
    end
  end

  // The output stage reads from a register so a stalled sink never sees data move.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else if (pop) begin
      out_valid_r <= 1'b1;
      out_data_r  <= mem_r[rd_ptr_r];
    end else if (rd_if.ready) begin
      out_valid_r <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// *** hdl/sadc_pkg.sv ***
// Types shared by the serial converter interface modules.
`include "sadc_defs.svh"

package sadc_pkg;

  typedef logic [`SADC_WORD_W-1:0] sadc_word_t;
  typedef logic [`SADC_CNT_W-1:0]  sadc_cnt_t;

  typedef enum logic [1:0] {
    SADC_RX_HUNT = 2'b00,
    SADC_RX_CTRL = 2'b01,
    SADC_RX_HOLD = 2'b10
  } sadc_rx_e;

endpackage

// *** hdl/sadc_stream_if.sv ***
// Valid/ready word stream between the converter interface modules.
`timescale 1ns/10ps
`default_nettype none

interface sadc_stream_if;
  import sadc_pkg::*;

  logic       valid;
  logic       ready;
  sadc_word_t data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// *** hdl/sadc_top.sv ***
// Serial link logic of the eight-channel sampling converter with its sample path.
//
// Notes on behaviour
// - Control bytes may overlap results so conversions repeat every 14 serial clocks, 10 at short resolution.
// - Result bits are the sample in straight unsigned binary, zero input gives zeros.
// - Short resolution ends conversion and output shifting four serial clocks earlier.
// - Power select 11 keeps the converter fully powered between conversions.
// - Power select 00 powers down after each conversion, waking at the next start.
// - Shutdown input low forces power-down regardless of power select.
// - Waking from auto power-down needs no extra cycles; first result is valid.
// - Select high keeps link logic idle whatever the serial clock does.
// - Serial clock edges are ignored at once when select rises.
// - Serial input is captured on rising serial clock edges.
// - Serial output changes after falling edges for the host to sample on rising.
// - Serial output is driven only while select is low.
// - Busy is driven only while select is low and rises after a falling edge.
// - Input is ignored until a high start bit opens the control byte.
// - Resolution bit selects short only while resolution enable is high.
// - Eighth control bit holds the sample; twelve clocks convert, thirteenth ends.
`timescale 1ns/10ps
`default_nettype none
`include "sadc_defs.svh"

module sadc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        serial_clock_in_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        serial_data_i,
  input  wire logic        resolution_enable_i,
  input  wire logic        power_off_input_low_n_i,
  output logic             serial_data_o,
  output logic             serial_data_oe_o,
  output logic             busy_o,
  output logic             busy_oe_o,
  input  wire sadc_pkg::sadc_word_t sample_data_i,
  input  wire logic        sample_valid_i,
  output logic             sample_ready_o,
  output logic             conv_start_o,
  output logic [2:0]       channel_select_bits_o,
  output logic             input_type_select_o,
  output logic             conv_short_o,
  output logic [1:0]       power_select_bits_o,
  output logic             power_down_o
);
  import sadc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Sample path in the system clock domain.

  sadc_stream_if in_if ();
  sadc_stream_if out_if ();

  assign in_if.valid    = sample_valid_i;
  assign in_if.data     = sample_data_i;
  assign sample_ready_o = in_if.ready;

  sadc_fifo #(
    .WIDTH (`SADC_WORD_W),
    .DEPTH (`SADC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .wr_if   (in_if),
    .rd_if   (out_if)
  );

  // Link-side toggles cross into the system domain.
  logic       conv_tg_r;
  logic       ack_tg_r;
  logic       done_tg_r;
  logic [2:0] conv_sync_r;
  logic [2:0] done_sync_r;
  logic [1:0] ack_sync_r;
  logic [1:0] power_off_input_low_sync_r;
  logic       req_tg_r;
  sadc_word_t hold_word_r;
  logic       hold_empty;
  logic       conv_evt;
  logic       done_evt;

  assign hold_empty   = (req_tg_r == ack_sync_r[1]);
  assign out_if.ready = hold_empty;
  assign conv_evt     = conv_sync_r[1] ^ conv_sync_r[2];
  assign done_evt     = done_sync_r[1] ^ done_sync_r[2];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_sync_r <= 3'h0;
    end else begin
      conv_sync_r <= {conv_sync_r[1:0], conv_tg_r};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_sync_r <= 3'h0;
    end else begin
      done_sync_r <= {done_sync_r[1:0], done_tg_r};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_sync_r <= 2'h0;
    end else begin
      ack_sync_r <= {ack_sync_r[0], ack_tg_r};
    end
  end

  // The shutdown synchroniser resets to the idle level of the pin, so leaving
  // reset does not fake two cycles of shutdown on power_down_o.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_off_input_low_sync_r <= 2'h3;
    end else begin
      power_off_input_low_sync_r <= {power_off_input_low_sync_r[0], power_off_input_low_n_i};
    end
  end

  // The holding word changes only after the link has taken the previous one,
  // so the link may read it without a gray code.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_tg_r    <= 1'b0;
      hold_word_r <= '0;
    end else if (hold_empty && out_if.valid) begin
      req_tg_r    <= ~req_tg_r;
      hold_word_r <= out_if.data;
    end
  end

  // Conversion fields stay stable for many serial clocks, long enough to be
  // sampled once the start toggle has been synchronised.
  logic [2:0] lk_chan_r;
  logic       lk_type_r;
  logic       lk_short_r;
  logic [1:0] lk_pd_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_start_o          <= 1'b0;
      channel_select_bits_o <= 3'h0;
      input_type_select_o   <= 1'b0;
      conv_short_o          <= 1'b0;
      power_select_bits_o   <= `SADC_PD_FULL;
    end else begin
      conv_start_o <= conv_evt;
      if (conv_evt) begin
        channel_select_bits_o <= lk_chan_r;
        input_type_select_o   <= lk_type_r;
        conv_short_o          <= lk_short_r;
        power_select_bits_o   <= lk_pd_r;
      end
    end
  end

  // Waking is a plain clear on the start event, so no settling wait exists.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_down_o <= 1'b0;
    end else if (!power_off_input_low_sync_r[1]) begin
      power_down_o <= 1'b1;
    end else if (conv_evt) begin
      power_down_o <= 1'b0;
    end else if (done_evt && power_select_bits_o == `SADC_PD_AUTO) begin
      power_down_o <= 1'b1;
    end else if (power_select_bits_o != `SADC_PD_AUTO) begin
      power_down_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial link domain. Select high holds the frame logic in reset, which
  // stops it at once even if the serial clock keeps running.

  logic link_rst_n;

  assign link_rst_n = rst_n_i & ~chip_select_n_i;

  logic [1:0] req_sync_r;
  logic [1:0] res_en_sync_r;
  sadc_rx_e   rx_state_r;
  sadc_cnt_t  rx_cnt_r;
  logic [`SADC_CTRL_W-1:0] ctrl_r;
  logic       start_r;
  sadc_word_t result_r;
  logic [`SADC_CTRL_W-1:0] ctrl_full;
  logic       ctrl_done;
  logic       short_sel;
  logic       word_avail;

  assign ctrl_full  = {ctrl_r[`SADC_CTRL_W-2:0], serial_data_i};
  assign ctrl_done  = (rx_state_r == SADC_RX_CTRL) && (rx_cnt_r == `SADC_CTRL_LAST);
  assign short_sel  = res_en_sync_r[1] & ctrl_full[`SADC_MODE_BIT];
  assign word_avail = (req_sync_r[1] != ack_tg_r);

  always_ff @(posedge serial_clock_in_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_sync_r <= 2'h0;
    end else begin
      req_sync_r <= {req_sync_r[0], req_tg_r};
    end
  end

  // The resolution pin is slow; a change reaches the receiver two rising edges late.
  always_ff @(posedge serial_clock_in_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_en_sync_r <= 2'h0;
    end else begin
      res_en_sync_r <= {res_en_sync_r[0], resolution_enable_i};
    end
  end

  // Control byte receiver on rising edges.
  always_ff @(posedge serial_clock_in_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_state_r <= SADC_RX_HUNT;
      rx_cnt_r   <= '0;
      ctrl_r     <= '0;
    end else begin
      case (rx_state_r)
        SADC_RX_HUNT: begin
          if (serial_data_i) begin
            rx_state_r <= SADC_RX_CTRL;
            rx_cnt_r   <= '0;
          end
        end
        SADC_RX_CTRL: begin
          ctrl_r   <= ctrl_full;
          rx_cnt_r <= rx_cnt_r + 1'b1;
          if (ctrl_done) begin
            // Hunting resumes early so the next byte overlaps the result.
            rx_state_r <= SADC_RX_HOLD;
            rx_cnt_r   <= short_sel ? `SADC_HOLDOFF_SHORT : `SADC_HOLDOFF_FULL;
          end
        end
        SADC_RX_HOLD: begin
          rx_cnt_r <= rx_cnt_r - 1'b1;
          if (rx_cnt_r == 4'h1) begin
            rx_state_r <= SADC_RX_HUNT;
          end
        end
        default: begin
          rx_state_r <= SADC_RX_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge serial_clock_in_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      start_r <= 1'b0;
    end else begin
      start_r <= ctrl_done;
    end
  end

  // Persistent across frames: these toggles must never lose their phase.
  always_ff @(posedge serial_clock_in_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_tg_r <= 1'b0;
    end else if (ctrl_done && !chip_select_n_i) begin
      conv_tg_r <= ~conv_tg_r;
    end
  end

  // A word is acknowledged only when a conversion really took it, so an empty
  // holding register is never reported as consumed.
  always_ff @(posedge serial_clock_in_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_tg_r <= 1'b0;
    end else if (ctrl_done && !chip_select_n_i && word_avail) begin
      ack_tg_r <= ~ack_tg_r;
    end
  end

  always_ff @(posedge serial_clock_in_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_r <= '0;
    end else if (ctrl_done && !chip_select_n_i) begin
      result_r <= word_avail ? hold_word_r : '0;
    end
  end

  // Fields change together with the start toggle and are read only after it crosses.
  always_ff @(posedge serial_clock_in_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lk_chan_r  <= 3'h0;
      lk_type_r  <= 1'b0;
      lk_short_r <= 1'b0;
      lk_pd_r    <= `SADC_PD_FULL;
    end else if (ctrl_done && !chip_select_n_i) begin
      lk_chan_r  <= ctrl_full[`SADC_CH_HI:`SADC_CH_LO];
      lk_type_r  <= ctrl_full[`SADC_TYPE_BIT];
      lk_short_r <= short_sel;
      lk_pd_r    <= ctrl_full[`SADC_PD_HI:`SADC_PD_LO];
    end
  end

  // Output shifter on falling edges.
  sadc_cnt_t  tx_cnt_r;
  sadc_word_t tx_shift_r;
  logic       pin_oe_r;

  always_ff @(negedge serial_clock_in_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_cnt_r      <= '0;
      tx_shift_r    <= '0;
      serial_data_o <= 1'b0;
      busy_o        <= 1'b0;
    end else if (start_r) begin
      busy_o        <= 1'b1;
      serial_data_o <= 1'b0;
      tx_shift_r    <= result_r;
      tx_cnt_r      <= lk_short_r ? `SADC_RES_SHORT : `SADC_RES_FULL;
    end else if (tx_cnt_r != '0) begin
      busy_o        <= 1'b0;
      serial_data_o <= tx_shift_r[`SADC_WORD_W-1];
      tx_shift_r    <= {tx_shift_r[`SADC_WORD_W-2:0], 1'b0};
      tx_cnt_r      <= tx_cnt_r - 1'b1;
    end else begin
      busy_o        <= 1'b0;
      serial_data_o <= 1'b0;
    end
  end

  always_ff @(negedge serial_clock_in_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_tg_r <= 1'b0;
    end else if (!start_r && tx_cnt_r == 4'h1) begin
      done_tg_r <= ~done_tg_r;
    end
  end

  // Enables drop asynchronously with select; they rise at the first falling
  // edge of a frame, before which both pins would only show low anyway.
  always_ff @(negedge serial_clock_in_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pin_oe_r <= 1'b0;
    end else begin
      pin_oe_r <= 1'b1;
    end
  end

  assign serial_data_oe_o = pin_oe_r;
  assign busy_oe_o        = pin_oe_r;
endmodule

`default_nettype wire
